//--- common/ogc_consts.svh
// Purpose: timing defaults for the optical gate command and status logic
// Assumes: 100 MHz local clock
// Notes: all counts in local clock cycles
`ifndef OGC_CONSTS_SVH
`define OGC_CONSTS_SVH
`define OGC_CNT_W 16
`define OGC_ACK_DELAY 16'd50
`define OGC_ACK_WIDTH 16'd100
`define OGC_ON_LAT 16'd20
`define OGC_OFF_LAT 16'd20
`define OGC_FAULT_DELAY 16'd10
`define OGC_BLOCK_TIME 16'd1000
`endif

//--- common/ogc_pkg.sv
// Purpose: shared types for the optical gate command and status logic
// Assumes: nothing
// Notes: counter width comes from the constants header
`include "ogc_consts.svh"
package ogc_pkg;
  typedef logic [`OGC_CNT_W-1:0] ogc_cnt_type;
endpackage

//--- common/ogc_chan_if.sv
// Purpose: bundle of one channel's signals between top and channel core
// Assumes: single clock
// Notes: top drives inputs, channel drives outputs
`timescale 1ns/1ns
interface ogc_chan_if;
  logic cmd;
  logic uv_fault;
  logic sc_fault;
  logic gate;
  logic status;
  logic fault;
  modport chan
  (
    input cmd,
    input uv_fault,
    input sc_fault,
    output gate,
    output status,
    output fault
  );
  modport top
  (
    output cmd,
    output uv_fault,
    output sc_fault,
    input gate,
    input status,
    input fault
  );
endinterface

//--- hw/ogc_channel.sv
// Purpose: one channel: edge command, gate latency, acknowledge and fault
// Assumes: cmd already synchronised to clock_i
// Notes: all timing parameters in cycles
`timescale 1ns/1ns
`include "ogc_consts.svh"
module ogc_channel
  import ogc_pkg::*;
#(
  parameter ogc_cnt_type ACK_DELAY = `OGC_ACK_DELAY,
  parameter ogc_cnt_type ACK_WIDTH = `OGC_ACK_WIDTH,
  parameter ogc_cnt_type ON_LAT = `OGC_ON_LAT,
  parameter ogc_cnt_type OFF_LAT = `OGC_OFF_LAT,
  parameter ogc_cnt_type FAULT_DELAY = `OGC_FAULT_DELAY,
  parameter ogc_cnt_type BLOCK_TIME = `OGC_BLOCK_TIME
)
(
  input wire logic clock_i,
  input wire logic resetn_i,
  ogc_chan_if.chan ch
);
  typedef struct packed {
    logic cmd_d;
    logic want;
    logic gate;
    logic lat_busy;
    ogc_cnt_type lat_cnt;
    logic ack_wait;
    logic ack_on;
    ogc_cnt_type ack_cnt;
    logic sc_seen;
    logic sc_dark;
    ogc_cnt_type sc_cnt;
    logic blocked;
    logic status;
  } ogc_chan_state_type;

  ogc_chan_state_type s_reg;
  ogc_chan_state_type s_next;
  logic edge_w;
  logic fault_now;

  always_comb
  begin
    s_next = s_reg;
    edge_w = ch.cmd ^ s_reg.cmd_d; // R06
    fault_now = ch.uv_fault | s_reg.sc_dark | ch.sc_fault;
    s_next.cmd_d = ch.cmd;
    // --------------------------------
    // Command path and latency
    // --------------------------------
    if (edge_w)
    begin
      s_next.want = ch.cmd; // R06
      s_next.lat_busy = 1'b1; // R07
      s_next.lat_cnt = ch.cmd ? ON_LAT : OFF_LAT; // R07
    end
    else if (s_reg.lat_busy)
    begin
      if (s_reg.lat_cnt <= 16'h0001)
      begin
        s_next.lat_busy = 1'b0;
        s_next.gate = s_reg.want & ~s_reg.blocked;
      end
      else
        s_next.lat_cnt = s_reg.lat_cnt - 16'h0001;
    end
    // Blocked turn-on is only re-armed by a fresh on edge after fault clears
    if (fault_now)
      s_next.blocked = 1'b1; // R05
    else if (edge_w && ch.cmd)
      s_next.blocked = 1'b0; // R12
    if (fault_now || s_reg.blocked)
      s_next.gate = 1'b0; // R04 R05 R11
    // --------------------------------
    // Acknowledge pulse
    // --------------------------------
    if (edge_w)
    begin
      s_next.ack_wait = 1'b1; // R10
      s_next.ack_on = 1'b0;
      s_next.ack_cnt = ACK_DELAY;
    end
    else if (s_reg.ack_wait || s_reg.ack_on)
    begin
      if (s_reg.ack_cnt <= 16'h0001)
      begin
        s_next.ack_on = s_reg.ack_wait; // R10
        s_next.ack_wait = 1'b0;
        s_next.ack_cnt = ACK_WIDTH;
      end
      else
        s_next.ack_cnt = s_reg.ack_cnt - 16'h0001;
    end
    // --------------------------------
    // Short circuit: delay to dark, then blocking time
    // --------------------------------
    if (!s_reg.sc_seen && !s_reg.sc_dark && ch.sc_fault)
    begin
      s_next.sc_seen = 1'b1; // R11
      s_next.sc_cnt = FAULT_DELAY;
    end
    else if (s_reg.sc_seen)
    begin
      if (s_reg.sc_cnt <= 16'h0001)
      begin
        s_next.sc_seen = 1'b0;
        s_next.sc_dark = 1'b1;
        s_next.sc_cnt = BLOCK_TIME;
      end
      else
        s_next.sc_cnt = s_reg.sc_cnt - 16'h0001;
    end
    else if (s_reg.sc_dark)
    begin
      if (s_reg.sc_cnt <= 16'h0001)
        s_next.sc_dark = 1'b0; // R12
      else
        s_next.sc_cnt = s_reg.sc_cnt - 16'h0001;
    end
    s_next.status = ~(ch.uv_fault | s_next.sc_dark | s_next.ack_on); // R04 R08 R09 R10
  end

  always_ff @(posedge clock_i or negedge resetn_i)
  begin
    if (!resetn_i)
      s_reg <= '0;
    else
      s_reg <= s_next;
  end

  assign ch.gate = s_reg.gate;
  assign ch.status = s_reg.status;
  assign ch.fault = s_reg.blocked;

  // --------------------------------
  // Checks
  // --------------------------------
  a_gate_fault_off: assert property (@(posedge clock_i) disable iff (!resetn_i)
    ch.uv_fault |=> !ch.gate) else $error("gate on during undervoltage"); // R04
  a_uv_dark: assert property (@(posedge clock_i) disable iff (!resetn_i)
    ch.uv_fault |=> !ch.status) else $error("status lit in undervoltage"); // R09
  a_blocked_no_gate: assert property (@(posedge clock_i) disable iff (!resetn_i)
    s_reg.blocked |-> !ch.gate) else $error("gate while blocked"); // R05
  a_gate_rises_edge: assert property (@(posedge clock_i) disable iff (!resetn_i)
    $rose(ch.gate) |-> s_reg.want) else $error("gate rose without on request"); // R07
  a_ack_starts: assert property (@(posedge clock_i) disable iff (!resetn_i)
    $rose(s_reg.ack_on) |-> $past(s_reg.ack_wait)) else $error("ack without delay"); // R10
  a_sc_off_now: assert property (@(posedge clock_i) disable iff (!resetn_i)
    ch.sc_fault |=> !ch.gate) else $error("gate on during short"); // R11
  a_ok_lit: assert property (@(posedge clock_i) disable iff (!resetn_i)
    $past(resetn_i) && !s_reg.sc_dark && !s_reg.ack_on && !ch.uv_fault && !$past(ch.uv_fault)
    |-> ch.status) else $error("status dark with no cause"); // R08
  a_sc_dark_ends: assert property (@(posedge clock_i) disable iff (!resetn_i)
    $fell(s_reg.sc_dark) |-> !s_reg.sc_seen) else $error("bad block end"); // R12
endmodule

//--- hw/ogc_top.sv
// Purpose: two independent optical command/status channels
// Assumes: optical receivers give logic levels, fault inputs asynchronous
// Notes: channels share nothing but the clock and reset
// How it works
// R01: Two channels run fully independent, no coupling.
// R02: Controller supplies dead-time; device adds none.
// R03: Each channel has own command input, status output.
// R04: Undervoltage darkens status and turns gate off.
// R05: Faulted channel blocks all gate commands.
// R06: Light on means turn on; edge triggered.
// R07: Gate follows after on or off latency.
// R08: Healthy channel holds status light on.
// R09: Fault keeps status dark while it lasts; code darkens a short only for BLOCK_TIME, after FAULT_DELAY.
// R10: Each edge: delay, then fixed dark acknowledge pulse.
// R11: Short circuit: gate off now, dark after delay.
// R12: Fault clears after blocking; next on re-enables.
// R13: All timings are cycle-count parameters.
// R14: Command inputs pass two flip-flops first.
`timescale 1ns/1ns
`include "ogc_consts.svh"
module ogc_top
  import ogc_pkg::*;
#(
  parameter ogc_cnt_type ACK_DELAY = `OGC_ACK_DELAY, // R13
  parameter ogc_cnt_type ACK_WIDTH = `OGC_ACK_WIDTH,
  parameter ogc_cnt_type ON_LAT = `OGC_ON_LAT,
  parameter ogc_cnt_type OFF_LAT = `OGC_OFF_LAT,
  parameter ogc_cnt_type FAULT_DELAY = `OGC_FAULT_DELAY,
  parameter ogc_cnt_type BLOCK_TIME = `OGC_BLOCK_TIME
)
(
  input wire logic clock_i,
  input wire logic resetn_i,
  input wire logic cmd_in_ch1_i,
  input wire logic cmd_in_ch2_i,
  input wire logic uv_fault_ch1_i,
  input wire logic uv_fault_ch2_i,
  input wire logic sc_fault_ch1_i,
  input wire logic sc_fault_ch2_i,
  output logic gate_ch1_o,
  output logic gate_ch2_o,
  output logic status_out_ch1_o,
  output logic status_out_ch2_o,
  output logic fault_ch1_o,
  output logic fault_ch2_o
);
  // --------------------------------
  // Synchronisers, two stages per async input
  // --------------------------------
  typedef struct packed {
    logic [5:0] s1;
    logic [5:0] s2;
  } ogc_sync_type;
  ogc_sync_type y_reg;
  ogc_sync_type y_next;

  always_comb
  begin
    y_next.s1 = {sc_fault_ch2_i, sc_fault_ch1_i, uv_fault_ch2_i, uv_fault_ch1_i,
      cmd_in_ch2_i, cmd_in_ch1_i};
    y_next.s2 = y_reg.s1; // R14
  end

  always_ff @(posedge clock_i or negedge resetn_i)
  begin
    if (!resetn_i)
      y_reg <= '0;
    else
      y_reg <= y_next;
  end

  ogc_chan_if ch1();
  ogc_chan_if ch2();
  // Separate instances give the channels no shared state
  assign ch1.cmd = y_reg.s2[0]; // R01 R03
  assign ch2.cmd = y_reg.s2[1]; // R01 R03
  assign ch1.uv_fault = y_reg.s2[2];
  assign ch2.uv_fault = y_reg.s2[3];
  assign ch1.sc_fault = y_reg.s2[4];
  assign ch2.sc_fault = y_reg.s2[5];

  ogc_channel #(.ACK_DELAY(ACK_DELAY), .ACK_WIDTH(ACK_WIDTH), .ON_LAT(ON_LAT),
    .OFF_LAT(OFF_LAT), .FAULT_DELAY(FAULT_DELAY), .BLOCK_TIME(BLOCK_TIME))
  u_ch1 (.clock_i(clock_i), .resetn_i(resetn_i), .ch(ch1.chan));
  ogc_channel #(.ACK_DELAY(ACK_DELAY), .ACK_WIDTH(ACK_WIDTH), .ON_LAT(ON_LAT),
    .OFF_LAT(OFF_LAT), .FAULT_DELAY(FAULT_DELAY), .BLOCK_TIME(BLOCK_TIME))
  u_ch2 (.clock_i(clock_i), .resetn_i(resetn_i), .ch(ch2.chan));

  // Channel outputs are already flops; status resets dark until first cycle
  assign gate_ch1_o = ch1.gate;
  assign gate_ch2_o = ch2.gate;
  assign status_out_ch1_o = ch1.status;
  assign status_out_ch2_o = ch2.status;
  assign fault_ch1_o = ch1.fault;
  assign fault_ch2_o = ch2.fault;
endmodule

//--- verification/ogc_ctrl_model.sv
// Purpose: controller model driving both optical command links
// Assumes: requests change at falling edges
// Notes: one leg must be dark before the other may light
`timescale 1ns/1ns
module ogc_ctrl_model
(
  input wire logic clock_i,
  input wire logic [1:0] want_i,
  output logic [1:0] cmd_o
);
  // Dead-time lives here; channel one wins a clash
  // Unknown until the first falling edge, which reset covers
  always @(negedge clock_i)
  begin
    cmd_o[0] <= want_i[0] & ~cmd_o[1];
    cmd_o[1] <= want_i[1] & ~want_i[0] & ~cmd_o[0];
  end
endmodule

//--- verification/tb_top.sv
// Purpose: self-checking bench for the two-channel command/status block
// Assumes: short timings keep the run brief
// Notes: windows allow for the input synchroniser
`timescale 1ns/1ns
module tb_top;
  import ogc_pkg::*;
  // ------
  // Setup
  // ------
  localparam ogc_cnt_type AD = 16'h4;
  localparam ogc_cnt_type AW = 16'h3;
  localparam ogc_cnt_type ONL = 16'h5;
  localparam ogc_cnt_type OFL = 16'h6;
  localparam ogc_cnt_type FD = 16'h3;
  localparam ogc_cnt_type BT = 16'h14;
  logic clock_i;
  logic resetn_i;
  logic [1:0] want, cmd, uv, sc, gate, st, flt;
  int failures, cmp_count, tg, td, w, o;
  ogc_ctrl_model ctrl (.clock_i(clock_i), .want_i(want), .cmd_o(cmd));
  ogc_top #(.ACK_DELAY(AD), .ACK_WIDTH(AW), .ON_LAT(ONL), .OFF_LAT(OFL),
    .FAULT_DELAY(FD), .BLOCK_TIME(BT)) uut (
    .clock_i(clock_i), .resetn_i(resetn_i),
    .cmd_in_ch1_i(cmd[0]), .cmd_in_ch2_i(cmd[1]),
    .uv_fault_ch1_i(uv[0]), .uv_fault_ch2_i(uv[1]),
    .sc_fault_ch1_i(sc[0]), .sc_fault_ch2_i(sc[1]),
    .gate_ch1_o(gate[0]), .gate_ch2_o(gate[1]),
    .status_out_ch1_o(st[0]), .status_out_ch2_o(st[1]),
    .fault_ch1_o(flt[0]), .fault_ch2_o(flt[1]));
  initial
  begin
    clock_i = 1'b0;
    forever #5 clock_i = ~clock_i;
  end
  task chk(input string n, input logic e, input logic g);
    cmp_count++;
    if (g !== e)
    begin
      failures++;
      $display("CHECK FAILED %s exp %b got %b", n, e, g);
    end
  endtask
  task rng(input string n, input int lo, input int hi, input int g);
    cmp_count++;
    if (g < lo || g > hi)
    begin
      failures++;
      $display("CHECK FAILED %s exp %0d..%0d got %0d", n, lo, hi, g);
    end
  endtask
  // Watch a channel 60 cycles; a short-circuit pulse ends at cycle 3
  task obs(input int c, input logic g);
    tg = -1;
    td = -1;
    w = 0;
    o = 0;
    for (int i = 1; i <= 60; i++)
    begin
      @(negedge clock_i);
      if (i == 3) sc <= 2'h0;
      if (tg < 0 && gate[c] === g) tg = i;
      if (st[c] !== 1'b1) w++;
      if (st[c] !== 1'b1 && td < 0) td = i;
      if (st[1 - c] !== 1'b1) o++;
    end
  endtask
  task idle(input int n);
    repeat (n) @(negedge clock_i);
  endtask
  // ----------
  // Scenarios
  // ----------
  task t_switch(input int c);
    want[c] <= 1'b1;
    obs(c, 1'b1);
    rng("on lat", ONL + 2, ONL + 7, tg);
    rng("ack dly", AD + 2, AD + 7, td);
    rng("ack wid", AW, AW, w);
    rng("other", 0, 0, o);
    want[c] <= 1'b0;
    obs(c, 1'b0);
    rng("off lat", OFL + 2, OFL + 7, tg);
    rng("ack dly", AD + 2, AD + 7, td);
    rng("ack wid", AW, AW, w);
    rng("other", 0, 0, o);
    chk("lit", 1'b1, st[c]);
  endtask
  task t_uv;
    want[1] <= 1'b1;
    idle(25);
    uv <= 2'h2;
    obs(1, 1'b0);
    rng("uv gate", 1, 5, tg);
    rng("uv dark", 1, 5, td);
    rng("uv span", 55, 60, w);
    want[1] <= 1'b0;
    idle(3);
    want[1] <= 1'b1;
    obs(1, 1'b1);
    rng("uv block", -1, -1, tg);
    chk("flag", 1'b1, flt[1]);
    uv <= 2'h0;
    obs(1, 1'b1);
    rng("no rearm", -1, -1, tg);
    rng("relit", 0, 4, w);
    want[1] <= 1'b0;
    idle(25);
    want[1] <= 1'b1;
    obs(1, 1'b1);
    rng("rearm", ONL + 2, ONL + 7, tg);
    chk("flag", 1'b0, flt[1]);
    want[1] <= 1'b0;
    idle(25);
  endtask
  task t_sc;
    want[0] <= 1'b1;
    idle(25);
    sc <= 2'h1;
    obs(0, 1'b0);
    rng("sc gate", 1, 5, tg);
    rng("sc dly", FD + 1, FD + 6, td);
    rng("sc span", BT - 1, BT + 2, w);
    rng("other", 0, 0, o);
    chk("lit", 1'b1, st[0]);
    chk("held off", 1'b0, gate[0]);
    chk("flag", 1'b1, flt[0]);
    want[0] <= 1'b0;
    idle(25);
    want[0] <= 1'b1;
    obs(0, 1'b1);
    rng("rearm", ONL + 2, ONL + 7, tg);
    chk("flag", 1'b0, flt[0]);
    want[0] <= 1'b0;
    idle(25);
  endtask
  task give_verdict;
    if (failures == 0 && cmp_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  initial
  begin
    failures = 0;
    cmp_count = 0;
    want = 2'h0;
    uv = 2'h0;
    sc = 2'h0;
    resetn_i = 1'b0;
    idle(16);
    resetn_i <= 1'b1;
    idle(4);
    chk("lit", 1'b1, st[0]);
    chk("lit", 1'b1, st[1]);
    t_switch(0);
    t_switch(1);
    t_uv;
    t_sc;
    give_verdict;
  end
  // Run needs under a thousand cycles
  initial
  begin
    repeat (5000) @(posedge clock_i);
    failures++;
    give_verdict;
  end
endmodule
